// >>> rtl/elic_core.v
// Eight-level vectored interrupt controller, top level.
// Sits on the core's register file port and on the CPU interrupt handshake;
// all inputs except the port 4 pins are synchronous to core_clk.
`timescale 1ns/1ps
`include "elic_map.vh"

module elic_core #(
   parameter        P4_PINS   = 8,
   parameter [47:0] ORD_TABLE = `ELIC_ORDER_TABLE
) (
   input  wire               core_clk,
   input  wire               sys_rst,
   input  wire [7:0]         regAddr,
   input  wire               regSet1,
   input  wire               regBank,
   input  wire [3:0]         regPage,
   input  wire               regWrEn,
   input  wire [7:0]         regWrData,
   input  wire               globalEnableInstr,
   input  wire               globalDisableInstr,
   input  wire               returnFromService,
   input  wire               ackStrobe,
   input  wire [3:0]         hwSrcPulse,
   input  wire [3:0]         hwSrcEn,
   input  wire [2:0]         swLevelReq,
   input  wire [P4_PINS-1:0] port4Pins,
   output reg  [7:0]         regRdData_q,
   output reg                intRequest_q,
   output reg  [2:0]         intLevel_q,
   output reg  [2:0]         intSource_q,
   output reg                intFast_q,
   output reg                globalEnable_q
);

   // Mode, mask and priority storage
   reg                  fastEnable_q;
   reg  [2:0]           fastSelect_q;
   reg  [7:0]           levelMask_q;
   reg  [7:0]           levelPrio_q;
   reg                  globalEnable_d;
   reg                  fastEnable_d;

   // Pending and status state
   reg  [3:0]           hwPend_q;
   reg  [3:0]           hwPend_d;
   reg  [P4_PINS-1:0]   p4Pend_q;
   reg  [P4_PINS-1:0]   p4Pend_d;
   reg  [7:0]           p4CfgHi_q;
   reg  [7:0]           p4CfgLo_q;
   reg  [7:0]           levelStatus_q;

   // Dispatch and read path
   reg  [2:0]           lowPin;
   reg  [7:0]           rdMux;
   wire                 winValid;
   wire [2:0]           winLevel;
   wire [7:0]           cand;
   wire [7:0]           levelSrcEn;
   wire [7:0]           ackVec;
   wire [P4_PINS-1:0]   edgeHit;
   wire [P4_PINS-1:0]   p4WrMask;
   wire                 ackTaken;
   wire                 selStatus;
   wire                 selMask;
   wire                 selMode;
   wire                 selPrio;
   wire                 selP4;
   wire                 selP4CfgHi;
   wire                 selP4CfgLo;
   wire                 selP4Pend;
   integer              k;

   // Address decode
   assign selStatus  = regSet1 && (regAddr == `ELIC_ADDR_STATUS);
   assign selMask    = regSet1 && (regAddr == `ELIC_ADDR_MASK);
   assign selMode    = regSet1 && (regAddr == `ELIC_ADDR_MODE);
   assign selPrio    = regSet1 && (regAddr == `ELIC_ADDR_PRIO) && (regBank == `ELIC_PRIO_BANK);
   assign selP4      = !regSet1 && (regPage == `ELIC_P4_PAGE);
   assign selP4CfgHi = selP4 && (regAddr == `ELIC_ADDR_P4_CFGHI);
   assign selP4CfgLo = selP4 && (regAddr == `ELIC_ADDR_P4_CFGLO);
   assign selP4Pend  = selP4 && (regAddr == `ELIC_ADDR_P4_PEND);

   // An acknowledge only counts against a request actually shown
   assign ackTaken = ackStrobe && intRequest_q;
   assign ackVec   = ackTaken ? (8'h01 << intLevel_q) : 8'h00;

   elic_p4_edge #(
      .PINS    (P4_PINS)
   ) uEdge (
      .core_clk(core_clk),
      .sys_rst (sys_rst),
      .pinIn   (port4Pins),
      .edgeCfg ({p4CfgHi_q, p4CfgLo_q}),
      .edgeHit (edgeHit)
   );

   // Global and fast enables; acknowledge overrides everything else on the global enable and leaves the fast enable alone
   always @* begin
      globalEnable_d = globalEnable_q;
      fastEnable_d   = fastEnable_q;
      if (regWrEn && selMode) begin
         globalEnable_d = regWrData[`ELIC_MODE_GIE];
         fastEnable_d   = regWrData[`ELIC_MODE_FASTEN];
      end
      if (globalEnableInstr || returnFromService) begin
         globalEnable_d = 1'b1;
      end
      if (globalDisableInstr) begin
         globalEnable_d = 1'b0;
      end
      if (ackTaken) begin
         globalEnable_d = 1'b0;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         globalEnable_q <= 1'b0;
         fastEnable_q   <= 1'b0;
      end else begin
         globalEnable_q <= globalEnable_d;
         fastEnable_q   <= fastEnable_d;
      end
   end

   // Left without reset: software must program these before enabling
   always @(posedge core_clk) begin
      if (regWrEn && selMode) begin
         fastSelect_q <= regWrData[`ELIC_MODE_FSEL_HI:`ELIC_MODE_FSEL_LO];
      end
      if (regWrEn && selMask) begin
         levelMask_q <= regWrData;
      end
      if (regWrEn && selPrio) begin
         levelPrio_q <= regWrData;
      end
   end

   // Port 4 edge configuration and pending register
   assign p4WrMask = (regWrEn && selP4Pend) ? regWrData[P4_PINS-1:0] : {P4_PINS{1'b1}};

   always @* begin
      // A new edge in the clearing cycle is kept
      p4Pend_d = (p4Pend_q & p4WrMask) | edgeHit;
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         p4CfgHi_q <= `ELIC_P4_CFG_RST;
         p4CfgLo_q <= `ELIC_P4_CFG_RST;
         p4Pend_q  <= `ELIC_P4_PEND_RST;
      end else begin
         if (regWrEn && selP4CfgHi) begin
            p4CfgHi_q <= regWrData;
         end
         if (regWrEn && selP4CfgLo) begin
            p4CfgLo_q <= regWrData;
         end
         p4Pend_q <= p4Pend_d;
      end
   end

   // Hardware-cleared pending for levels 0 to 3; no register reaches them
   always @* begin
      hwPend_d = (hwPend_q & ~ackVec[3:0]) | hwSrcPulse;
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         hwPend_q <= 4'h0;
      end else begin
         hwPend_q <= hwPend_d;
      end
   end

   // Status keeps recording whatever the global enable says
   always @(posedge core_clk) begin
      if (sys_rst) begin
         levelStatus_q <= `ELIC_STATUS_RST;
      end else begin
         levelStatus_q <= {|p4Pend_d, swLevelReq, hwPend_d};
      end
   end

   // Dispatch candidates
   assign levelSrcEn = {4'hf, hwSrcEn};
   assign cand = levelStatus_q & levelMask_q & levelSrcEn & {8{globalEnable_q}};

   elic_prio #(
      .ORD_TABLE(ORD_TABLE)
   ) uPrio (
      .cand    (cand),
      .prio    (levelPrio_q),
      .winValid(winValid),
      .winLevel(winLevel)
   );

   // Port 4 pins share level 7; the lowest pin has the lower vector
   always @* begin
      lowPin = 3'd0;
      for (k = P4_PINS - 1; k >= 0; k = k - 1) begin
         if (p4Pend_q[k]) begin
            lowPin = k[2:0];
         end
      end
   end

   // Request follows the winner each cycle, so masking withdraws it
   always @(posedge core_clk) begin
      if (sys_rst) begin
         intRequest_q <= 1'b0;
         intLevel_q   <= 3'd0;
         intSource_q  <= 3'd0;
         intFast_q    <= 1'b0;
      end else begin
         intRequest_q <= winValid && !ackTaken;
         if (winValid) begin
            intLevel_q  <= winLevel;
            intSource_q <= (winLevel == `ELIC_P4_LEVEL) ? lowPin : 3'd0;
         end
         intFast_q <= winValid && !ackTaken && fastEnable_q && (winLevel == fastSelect_q);
      end
   end

   // Registered read port; writes to status are ignored
   always @* begin
      rdMux = 8'h00;
      if (selStatus) begin
         rdMux = levelStatus_q;
      end else if (selMask) begin
         rdMux = levelMask_q;
      end else if (selMode) begin
         rdMux = {3'b000, fastSelect_q, fastEnable_q, globalEnable_q};
      end else if (selPrio) begin
         rdMux = levelPrio_q;
      end else if (selP4CfgHi) begin
         rdMux = p4CfgHi_q;
      end else if (selP4CfgLo) begin
         rdMux = p4CfgLo_q;
      end else if (selP4Pend) begin
         rdMux = p4Pend_q;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         regRdData_q <= 8'h00;
      end else begin
         regRdData_q <= rdMux;
      end
   end

endmodule

// >>> rtl/elic_map.vh
// Constants of the eight-level interrupt controller: register offsets,
// field positions, reset values and encodings. Definitions only.
`ifndef ELIC_MAP_VH
`define ELIC_MAP_VH

// Register offsets in register set 1
`define ELIC_ADDR_STATUS   8'hdc
`define ELIC_ADDR_MASK     8'hdd
`define ELIC_ADDR_MODE     8'hde
`define ELIC_ADDR_PRIO     8'hff
`define ELIC_PRIO_BANK     1'b0

// Port 4 interrupt registers, page-addressed
`define ELIC_P4_PAGE       4'h8
`define ELIC_ADDR_P4_CFGHI 8'h0e
`define ELIC_ADDR_P4_CFGLO 8'h0f
`define ELIC_ADDR_P4_PEND  8'h10

// Mode register fields
`define ELIC_MODE_GIE      0
`define ELIC_MODE_FASTEN   1
`define ELIC_MODE_FSEL_LO  2
`define ELIC_MODE_FSEL_HI  4

// Priority register fields
`define ELIC_PRIO_ORD_HI   7
`define ELIC_PRIO_ORD_MID  4
`define ELIC_PRIO_ORD_LO   1
`define ELIC_PRIO_A        0
`define ELIC_PRIO_B_TOP    2
`define ELIC_PRIO_B_SUB    3
`define ELIC_PRIO_C_TOP    5
`define ELIC_PRIO_C_SUB    6

// Group order table, 6 bits per order code, code 7 leftmost;
// each entry lists group ids highest first (0 = A, 1 = B, 2 = C)
`define ELIC_ORDER_TABLE   48'h189921486606

// Edge configuration codes per port 4 pin
`define ELIC_EDGE_OFF      2'b00
`define ELIC_EDGE_FALL     2'b01
`define ELIC_EDGE_RISE     2'b10
`define ELIC_EDGE_BOTH     2'b11

// Reset values and the port 4 dispatch level
`define ELIC_STATUS_RST    8'h00
`define ELIC_P4_PEND_RST   8'h00
`define ELIC_P4_CFG_RST    8'h00
`define ELIC_P4_LEVEL      3'd7

`endif

// >>> rtl/elic_p4_edge.v
// Port 4 pin edge detectors, one per pin.
// Pins are asynchronous; each passes two flip-flops before edge logic.
`timescale 1ns/1ps
`include "elic_map.vh"

module elic_p4_edge #(
   parameter PINS = 8
) (
   input  wire              core_clk,
   input  wire              sys_rst,
   input  wire [PINS-1:0]   pinIn,
   input  wire [2*PINS-1:0] edgeCfg,
   output wire [PINS-1:0]   edgeHit
);

   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1) begin : gPin
         reg        meta_q;
         reg        sync_q;
         reg        prev_q;
         wire [1:0] cfg;
         wire       fall;
         wire       rise;
         // Idle high, matching the pull-up, so release gives no edge
         always @(posedge core_clk) begin
            if (sys_rst) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
               prev_q <= 1'b1;
            end else begin
               meta_q <= pinIn[g];
               sync_q <= meta_q;
               prev_q <= sync_q;
            end
         end
         assign cfg  = edgeCfg[2*g+1:2*g];
         assign fall = prev_q & ~sync_q;
         assign rise = ~prev_q & sync_q;
         assign edgeHit[g] = ((cfg == `ELIC_EDGE_FALL) & fall) |
                             ((cfg == `ELIC_EDGE_RISE) & rise) |
                             ((cfg == `ELIC_EDGE_BOTH) & (fall | rise));
      end
   endgenerate

endmodule

// >>> rtl/elic_prio.v
// Level priority resolver: picks the highest ranked candidate level.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "elic_map.vh"

module elic_prio #(
   parameter [47:0] ORD_TABLE = `ELIC_ORDER_TABLE
) (
   input  wire [7:0] cand,
   input  wire [7:0] prio,
   output reg        winValid,
   output reg  [2:0] winLevel
);

   reg  [11:0] seqA;
   reg  [11:0] seqB;
   reg  [11:0] seqC;
   reg  [5:0]  order;
   reg  [35:0] slots;
   reg  [3:0]  slot;
   wire [2:0]  ordCode;
   integer     i;

   // Group order from three scattered bits
   assign ordCode = {prio[`ELIC_PRIO_ORD_HI], prio[`ELIC_PRIO_ORD_MID], prio[`ELIC_PRIO_ORD_LO]};

   function [11:0] pickGroup;
      input [1:0] id;
      input [11:0] a;
      input [11:0] b;
      input [11:0] c;
      begin
         case (id)
            2'd0:    pickGroup = a;
            2'd1:    pickGroup = b;
            default: pickGroup = c;
         endcase
      end
   endfunction

   // Each slot is {valid, level}; group A has one empty slot
   always @* begin
      seqA = prio[`ELIC_PRIO_A] ? {4'h9, 4'h8, 4'h0} : {4'h8, 4'h9, 4'h0};
      case ({prio[`ELIC_PRIO_B_TOP], prio[`ELIC_PRIO_B_SUB]})
         2'b00:   seqB = {4'ha, 4'hb, 4'hc};
         2'b01:   seqB = {4'ha, 4'hc, 4'hb};
         2'b10:   seqB = {4'hb, 4'hc, 4'ha};
         default: seqB = {4'hc, 4'hb, 4'ha};
      endcase
      case ({prio[`ELIC_PRIO_C_TOP], prio[`ELIC_PRIO_C_SUB]})
         2'b00:   seqC = {4'hd, 4'he, 4'hf};
         2'b01:   seqC = {4'hd, 4'hf, 4'he};
         2'b10:   seqC = {4'he, 4'hf, 4'hd};
         default: seqC = {4'hf, 4'he, 4'hd};
      endcase
      order = ORD_TABLE[ordCode*6 +: 6];
      slots = {pickGroup(order[5:4], seqA, seqB, seqC),
               pickGroup(order[3:2], seqA, seqB, seqC),
               pickGroup(order[1:0], seqA, seqB, seqC)};
      winValid = 1'b0;
      winLevel = 3'd0;
      slot     = 4'h0;
      // First requesting slot in rank order wins
      for (i = 0; i < 9; i = i + 1) begin
         slot = slots[35-4*i -: 4];
         if (!winValid && slot[3] && cand[slot[2:0]]) begin
            winValid = 1'b1;
            winLevel = slot[2:0];
         end
      end
   end

endmodule

// >>> verif/elic_core_properties.sv
// Checker of the CPU handshake and global enable of the interrupt controller.
// Sees only the top-level ports; mask and priority contents are left to the bench.
`timescale 1ns/1ps
module elic_core_properties (
   input wire       core_clk,
   input wire       sys_rst,
   input wire [7:0] regAddr,
   input wire       regSet1,
   input wire       regWrEn,
   input wire       globalEnableInstr,
   input wire       globalDisableInstr,
   input wire       returnFromService,
   input wire       ackStrobe,
   input wire [3:0] hwSrcEn,
   input wire [2:0] swLevelReq,
   input wire [7:0] regRdData_q,
   input wire       intRequest_q,
   input wire [2:0] intLevel_q,
   input wire [2:0] intSource_q,
   input wire       intFast_q,
   input wire       globalEnable_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire taken = ackStrobe && intRequest_q;
   wire quiet = !regWrEn && !globalDisableInstr;
   wire anyEn = globalEnableInstr || returnFromService;

   // Reset itself is the cause here, so it cannot also disable the check
   chk_reset_clears: assert property (disable iff (1'b0) sys_rst |=> !intRequest_q && !globalEnable_q)
      else $error("reset left request or enable set");
   chk_ack_drops: assert property (taken |=> !intRequest_q && !globalEnable_q)
      else $error("acknowledge did not drop request and enable");
   chk_rise_enabled: assert property ($rose(intRequest_q) |-> $past(globalEnable_q))
      else $error("request raised while globally disabled");
   chk_enable_sets: assert property (anyEn && !taken && quiet |=> globalEnable_q)
      else $error("enable pulse did not set global enable");
   chk_disable_clears: assert property (globalDisableInstr && !anyEn && !regWrEn |=> !globalEnable_q)
      else $error("disable pulse did not clear global enable");
   chk_req_holds: assert property (intRequest_q && !ackStrobe && quiet && $stable(hwSrcEn)
      && $stable(swLevelReq) |=> intRequest_q)
      else $error("request dropped without acknowledge");
   chk_src_zero: assert property (intRequest_q && intLevel_q != 3'd7 |-> intSource_q == 3'd0)
      else $error("source index set outside level seven");
   chk_unmapped_read: assert property (regSet1 && regAddr < 8'hdc |=> regRdData_q == 8'h00)
      else $error("unmapped address read not zero");
   cover property (taken && intLevel_q == 3'd7);
   cover property (taken && intFast_q);
   cover property ($rose(intRequest_q) && intLevel_q == 3'd6);
endmodule
bind elic_core elic_core_properties chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regSet1(regSet1), .regWrEn(regWrEn),
   .globalEnableInstr(globalEnableInstr), .globalDisableInstr(globalDisableInstr),
   .returnFromService(returnFromService), .ackStrobe(ackStrobe), .hwSrcEn(hwSrcEn),
   .swLevelReq(swLevelReq), .regRdData_q(regRdData_q), .intRequest_q(intRequest_q),
   .intLevel_q(intLevel_q), .intSource_q(intSource_q), .intFast_q(intFast_q),
   .globalEnable_q(globalEnable_q));

// >>> verif/elic_cpu_model.sv
// CPU side model: acknowledges a shown request after ackDelay cycles,
// then returns from service after a fixed stretch when retEn is high.
`timescale 1ns/1ps
module elic_cpu_model (
   input  wire       core_clk,
   input  wire       sys_rst,
   input  wire       intRequest_q,
   input  wire [3:0] ackDelay,
   input  wire       retEn,
   output reg        ackStrobe,
   output reg        returnFromService,
   output reg  [7:0] ackCnt
);
   reg       reqSeen;
   reg       rstSeen;
   reg       ackNext;
   reg       retNext;
   reg [3:0] waitCnt;
   reg [2:0] svcCnt;
   initial begin
      ackStrobe = 1'b0;
      returnFromService = 1'b0;
      ackCnt = 8'h00;
      waitCnt = 4'h0;
      svcCnt = 3'h0;
   end
   // Inputs are sampled at the edge; each output is driven once, just after it
   always @(posedge core_clk) begin
      reqSeen = intRequest_q;
      rstSeen = sys_rst;
      ackNext = 1'b0;
      retNext = 1'b0;
      if (rstSeen) begin
         waitCnt = 4'h0;
         svcCnt = 3'h0;
      end else if (svcCnt != 3'h0) begin
         svcCnt = svcCnt - 3'h1;
         retNext = (svcCnt == 3'h0) && retEn;
      end else if (reqSeen && waitCnt == ackDelay) begin
         ackNext = 1'b1;
         waitCnt = 4'h0;
         svcCnt = 3'h4;
      end else begin
         waitCnt = reqSeen ? waitCnt + 4'h1 : 4'h0;
      end
      #1;
      ackStrobe = ackNext;
      returnFromService = retNext;
      if (rstSeen) begin
         ackCnt = 8'h00;
      end else if (ackNext) begin
         ackCnt = ackCnt + 8'h01;
      end
   end
endmodule

// >>> verif/elic_core_tb.sv
// Testbench of the interrupt controller: register tasks, ordering and port 4 runs.
// Assumes the CPU model acknowledges every request that it sees.
`timescale 1ns/1ps
module elic_core_tb;
   reg         core_clk = 0;
   reg         sys_rst = 1;
   reg  [7:0]  regAddr = 0;
   reg         regSet1 = 1;
   reg         bank = 0;
   reg         regWrEn = 0;
   reg  [7:0]  regWrData = 0;
   reg         eiP = 0;
   reg         diP = 0;
   reg  [3:0]  hwPulse = 0;
   reg  [3:0]  hwEn = 4'hf;
   reg  [2:0]  swReq = 0;
   reg  [7:0]  pins = 8'hff;
   reg  [3:0]  ackDelay = 0;
   reg         retEn = 1;
   reg  [27:0] gotSeq = 0;
   reg  [7:0]  fastSeq = 0;
   reg  [2:0]  gotSrc = 0;
   reg  [7:0]  base;
   reg  [7:0]  p;
   reg  [27:0] e;
   wire [7:0]  rdData;
   wire [7:0]  ackCnt;
   wire [2:0]  lvl;
   wire [2:0]  src;
   wire        req;
   wire        fast;
   wire        gie;
   wire        ack;
   wire        ret;
   integer     error_cnt = 0;
   integer     checked = 0;
   integer     cycles = 0;
   integer     i;
   integer     k;
   localparam [71:0] PL = 72'h00_02_10_12_80_82_90_92_ef;
   localparam [251:0] OL = 252'h0123456_2345601_0123456_2340156_5601234_5623401_0156234_0123456_6543210;

   always #2 core_clk = ~core_clk;

   elic_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regSet1(regSet1),
      .regBank(bank), .regPage(4'h8), .regWrEn(regWrEn), .regWrData(regWrData),
      .globalEnableInstr(eiP), .globalDisableInstr(diP), .returnFromService(ret), .ackStrobe(ack),
      .hwSrcPulse(hwPulse), .hwSrcEn(hwEn), .swLevelReq(swReq), .port4Pins(pins), .regRdData_q(rdData),
      .intRequest_q(req), .intLevel_q(lvl), .intSource_q(src), .intFast_q(fast), .globalEnable_q(gie));
   elic_cpu_model cpu (.core_clk(core_clk), .sys_rst(sys_rst), .intRequest_q(req), .ackDelay(ackDelay),
      .retEn(retEn), .ackStrobe(ack), .returnFromService(ret), .ackCnt(ackCnt));

   // Record each taken acknowledge; the software request of levels 4 to 6 drops then
   always @(posedge core_clk)
      if (ack && req) begin
         gotSeq <= {gotSeq[23:0], 1'b0, lvl};
         fastSeq <= {fastSeq[6:0], fast};
         gotSrc <= src;
         if (lvl >= 3'd4 && lvl != 3'd7) swReq <= #1 swReq & ~(3'b001 << (lvl - 3'd4));
      end

   task chk(input [27:0] seen, input [27:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task wr(input s1, input [7:0] a, input [7:0] d);
      begin
         tick(1);
         regSet1 = s1;
         regAddr = a;
         regWrData = d;
         regWrEn = 1;
         tick(1);
         regWrEn = 0;
      end
   endtask
   task rd(input s1, input [7:0] a, input [7:0] m, input [7:0] x);
      begin
         regSet1 = s1;
         regAddr = a;
         tick(1);
         chk(rdData & m, x);
      end
   endtask
   task pls(input [3:0] h);
      begin
         hwPulse = h;
         tick(1);
         hwPulse = 0;
      end
   endtask
   task instr(input en, input dis);
      begin
         eiP = en;
         diP = dis;
         tick(1);
         eiP = 0;
         diP = 0;
      end
   endtask
   task waitAck(input [7:0] n);
      begin
         i = 0;
         while (ackCnt !== n && i < 300) begin
            tick(1);
            i = i + 1;
         end
         chk(ackCnt, n);
      end
   endtask
   task report_and_stop;
      begin
         if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask

   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 6000) begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end
   end

   initial begin
      tick(16);
      sys_rst = 0;
      chk(gie, 0);
      rd(1, 8'hde, 8'h03, 8'h00);
      rd(1, 8'hdc, 8'hff, 8'h00);
      wr(1, 8'hdd, 8'hff);
      wr(1, 8'hff, 8'h00);
      wr(1, 8'hde, 8'h00);
      rd(1, 8'hdd, 8'hff, 8'hff);
      bank = 1;
      wr(1, 8'hff, 8'h5a);
      bank = 0;
      rd(1, 8'hff, 8'hff, 8'h00);
      rd(1, 8'h33, 8'hff, 8'h00);
      // Sources fire while globally disabled: recorded, not dispatched
      swReq = 3'b111;
      pls(4'hf);
      tick(4);
      chk(req, 0);
      wr(1, 8'hdc, 8'h00);
      rd(1, 8'hdc, 8'hff, 8'h7f);
      for (k = 0; k < 9; k = k + 1) begin
         if (k > 0) begin
            swReq = 3'b111;
            pls(4'hf);
         end
         p = PL[71 - 8 * k -: 8];
         e = OL[251 - 28 * k -: 28];
         wr(1, 8'hff, p);
         gotSeq = 0;
         base = ackCnt;
         instr(1, 0);
         waitAck(base + 8'd7);
         tick(8);
         chk(gotSeq, e);
         instr(0, 1);
      end
      rd(1, 8'hdc, 8'hff, 8'h00);
      base = ackCnt;
      wr(1, 8'hdd, 8'hfd);
      hwEn = 4'he;
      pls(4'h3);
      instr(1, 0);
      tick(20);
      chk(req, 0);
      wr(1, 8'hdd, 8'hff);
      waitAck(base + 8'd1);
      tick(8);
      hwEn = 4'hf;
      waitAck(base + 8'd2);
      tick(8);
      chk(gotSeq[7:0], 8'h10);
      wr(1, 8'hde, 8'h07);
      pls(4'h2);
      waitAck(base + 8'd3);
      tick(8);
      pls(4'h1);
      waitAck(base + 8'd4);
      tick(8);
      chk(fastSeq[1:0], 2'b10);
      instr(0, 1);
      wr(0, 8'h0e, 8'h55);
      wr(0, 8'h0f, 8'h55);
      wr(0, 8'h10, 8'h00);
      retEn = 0;
      ackDelay = 5;
      instr(1, 0);
      pins = 8'h77;
      waitAck(base + 8'd5);
      tick(8);
      chk({gotSeq[3:0], 1'b0, gotSrc}, 8'h73);
      chk(gie, 0);
      rd(0, 8'h10, 8'hff, 8'h88);
      wr(0, 8'h10, 8'hff);
      rd(0, 8'h10, 8'hff, 8'h88);
      wr(0, 8'h10, 8'h77);
      rd(0, 8'h10, 8'hff, 8'h00);
      rd(1, 8'hdc, 8'h80, 8'h00);
      wr(0, 8'h0f, 8'h00);
      pins = 8'h73;
      tick(8);
      rd(0, 8'h10, 8'hff, 8'h00);
      pls(4'h1);
      tick(3);
      rd(1, 8'hdc, 8'h01, 8'h01);
      sys_rst = 1;
      tick(2);
      sys_rst = 0;
      rd(1, 8'hdc, 8'hff, 8'h00);
      chk(gie, 0);
      report_and_stop;
   end
endmodule
